// *** common/sadc_defines.svh ***
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef SADC_DEFINES_SVH
`define SADC_DEFINES_SVH
`define SADC_OFS_MODE_A 8'h00
`define SADC_OFS_CONV_TIME 8'h04
`define SADC_OFS_HW_TRIG 8'h08
`define SADC_OFS_CHAN_SEL 8'h0C
`define SADC_OFS_PF_MODE 8'h10
`define SADC_OFS_PF_THRESH 8'h14
`define SADC_OFS_IRQ_STAT 8'h18
`define SADC_OFS_IRQ_MASK 8'h1C
`define SADC_OFS_PORT_EN 8'h20
`define SADC_OFS_RES_WORD 8'h40
`define SADC_OFS_RES_HIGH 8'h80
`define SADC_BIT_CE 7
`define SADC_BIT_MD_HI 5
`define SADC_BIT_MD_LO 4
`define SADC_BIT_ETS_HI 3
`define SADC_BIT_ETS_LO 2
`define SADC_BIT_TMD 1
`define SADC_BIT_EF 0
`define SADC_BIT_PF_EN 7
`define SADC_BIT_PF_GE 6
`define SADC_MODE_A_WMASK 8'hBE
`define SADC_CONV_TIME_WMASK 8'h87
`define SADC_HW_TRIG_WMASK 8'h01
`define SADC_PF_MODE_WMASK 8'hC0
`define SADC_RESET_BYTE 8'h00
`define SADC_STEP_BASE 4'h1
`endif

// *** common/sadc_pkg.sv ***
// Types shared by the converter control files
package sadc_pkg;
  typedef enum logic [1:0] {
    SADC_CONT_SELECT,
    SADC_CONT_SCAN,
    SADC_ONESHOT_SELECT,
    SADC_ONESHOT_SCAN
  } sadc_mode_type;
  typedef struct packed {
    logic ce;
    sadc_mode_type mode;
    logic [1:0] edge_sel;
    logic hw_trig;
  } sadc_ctrl_type;
  typedef struct packed {
    logic pf_en;
    logic pf_ge;
    logic [7:0] thresh;
  } sadc_pf_type;
endpackage : sadc_pkg

// *** hdl/sadc_ctrl.sv ***
// Converter control top: AXI4-Lite registers, trigger logic, scan sequencing, results
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sadc_defines.svh"
module sadc_ctrl #(
  parameter int NUM_CH = 10,
  parameter int RES_BITS = 10
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_trigger_pin_i,
  input wire logic timer_trigger_i,
  input wire logic comparator_i,
  output logic [RES_BITS-1:0] dac_code_o,
  output logic [3:0] analog_input_sel_o,
  output logic sample_o,
  output logic [NUM_CH-1:0] analog_pin_enable_o,
  output logic conversion_end_irq_o,
  output logic irq_o
);
  localparam logic [3:0] LAST_CH = 4'(NUM_CH - 1);

  sadc_pkg::sadc_ctrl_type ctl_r;
  sadc_pkg::sadc_ctrl_type ctl_nxt;
  sadc_pkg::sadc_pf_type pf_r;
  sadc_pkg::sadc_pf_type pf_nxt;
  logic [7:0] conv_time_reg_r;
  logic [7:0] conv_time_reg_nxt;
  logic [7:0] hw_trigger_select_reg_r;
  logic [7:0] hw_trigger_select_reg_nxt;
  logic [3:0] channel_select_reg_r;
  logic [3:0] channel_select_reg_nxt;
  logic [NUM_CH-1:0] port_en_r;
  logic [NUM_CH-1:0] port_en_nxt;
  logic irq_stat_r;
  logic irq_stat_nxt;
  logic irq_mask_r;
  logic irq_mask_nxt;
  logic [RES_BITS-1:0] result_mem_r [NUM_CH];
  logic [3:0] cur_ch_r;
  logic [3:0] cur_ch_nxt;
  logic armed_r;
  logic armed_nxt;

  logic aw_hold_r;
  logic aw_hold_nxt;
  logic [7:0] aw_addr_r;
  logic [7:0] aw_addr_nxt;
  logic w_hold_r;
  logic w_hold_nxt;
  logic [31:0] w_data_r;
  logic [31:0] w_data_nxt;
  logic [3:0] w_strb_r;
  logic [3:0] w_strb_nxt;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;

  logic [2:0] pin_sync_r;
  logic pin_level_r;
  logic pin_level_nxt;
  logic pin_fall;
  logic pin_rise;
  logic [3:0] div_cnt_r;
  logic [3:0] div_cnt_nxt;
  logic step_en;
  logic do_write;
  logic ctl_write;
  logic trig_edge;
  logic start;
  logic abort;
  logic busy;
  logic done;
  logic [RES_BITS-1:0] result;
  logic pf_hit;
  logic end_event;
  logic rd_stat;

  // Helpers that decode a register address, shared by the read and write paths, and merge a masked write byte
  function automatic logic is_res_word(input logic [7:0] a);
    is_res_word = (a >= `SADC_OFS_RES_WORD) && (a < `SADC_OFS_RES_WORD + 8'(NUM_CH * 4));
  endfunction : is_res_word

  function automatic logic is_res_high(input logic [7:0] a);
    is_res_high = (a >= `SADC_OFS_RES_HIGH) && (a < `SADC_OFS_RES_HIGH + 8'(NUM_CH * 4));
  endfunction : is_res_high

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] nw,
                                             input logic [7:0] wmask, input logic en);
    merge_byte = en ? ((old & ~wmask) | (nw & wmask)) : old;
  endfunction : merge_byte

  // External trigger pin: three stages; the settled level moves once stages two and three agree
  // The chain keeps sampling in reset, so the idle pin level gives no false edge at release
  assign pin_level_nxt = (pin_sync_r[2] == pin_sync_r[1]) ? pin_sync_r[2] : pin_level_r;
  assign pin_fall = pin_level_r & ~pin_level_nxt;
  assign pin_rise = ~pin_level_r & pin_level_nxt;

  always_ff @(posedge core_clk_i)
  begin
    pin_sync_r <= {pin_sync_r[1:0], external_trigger_pin_i};
    if (sys_rst_i)
      pin_level_r <= pin_sync_r[2];
    else
      pin_level_r <= pin_level_nxt;
  end

  always_comb
  begin
    unique case (ctl_r.edge_sel)
      2'b00: trig_edge = 1'b0;
      2'b01: trig_edge = pin_fall;
      2'b10: trig_edge = pin_rise;
      2'b11: trig_edge = pin_fall | pin_rise;
    endcase
  end

  // Step enable: conversion time field scales the divider
  always_comb
  begin
    div_cnt_nxt = div_cnt_r - 4'h1;
    step_en = 1'b0;
    if (div_cnt_r == 4'h0)
    begin
      step_en = 1'b1;
      div_cnt_nxt = `SADC_STEP_BASE + {1'b0, conv_time_reg_r[2:0]};
    end
  end

  // AXI4-Lite write side: address and data may arrive in either order
  assign do_write = aw_hold_r && w_hold_r && !bvalid_r;
  assign ctl_write = do_write && (aw_addr_r == `SADC_OFS_MODE_A || aw_addr_r == `SADC_OFS_HW_TRIG
                     || aw_addr_r == `SADC_OFS_CHAN_SEL || aw_addr_r == `SADC_OFS_PF_MODE
                     || aw_addr_r == `SADC_OFS_PF_THRESH);
  assign rd_stat = s_axi_arvalid && !rvalid_r && (s_axi_araddr == `SADC_OFS_IRQ_STAT);

  always_comb
  begin
    aw_hold_nxt = aw_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_hold_nxt = w_hold_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    ctl_nxt = ctl_r;
    pf_nxt = pf_r;
    conv_time_reg_nxt = conv_time_reg_r;
    hw_trigger_select_reg_nxt = hw_trigger_select_reg_r;
    channel_select_reg_nxt = channel_select_reg_r;
    port_en_nxt = port_en_r;
    irq_mask_nxt = irq_mask_r;
    if (s_axi_awvalid && !aw_hold_r)
    begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && !w_hold_r)
    begin
      w_hold_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (do_write)
    begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = 2'b00;
      unique case (aw_addr_r)
        `SADC_OFS_MODE_A:
        begin
          // Bit 0 is the read-only busy flag and is never taken from the write
          if (w_strb_r[0])
          begin
            ctl_nxt.ce = w_data_r[`SADC_BIT_CE];
            ctl_nxt.mode = sadc_pkg::sadc_mode_type'(w_data_r[`SADC_BIT_MD_HI:`SADC_BIT_MD_LO]);
            ctl_nxt.edge_sel = w_data_r[`SADC_BIT_ETS_HI:`SADC_BIT_ETS_LO];
            ctl_nxt.hw_trig = w_data_r[`SADC_BIT_TMD];
          end
        end
        `SADC_OFS_CONV_TIME:
          conv_time_reg_nxt = merge_byte(conv_time_reg_r, w_data_r[7:0],
                                         `SADC_CONV_TIME_WMASK, w_strb_r[0]);
        `SADC_OFS_HW_TRIG:
          hw_trigger_select_reg_nxt = merge_byte(hw_trigger_select_reg_r, w_data_r[7:0],
                                                 `SADC_HW_TRIG_WMASK, w_strb_r[0]);
        `SADC_OFS_CHAN_SEL:
          if (w_strb_r[0] && w_data_r[3:0] <= LAST_CH)
            channel_select_reg_nxt = w_data_r[3:0];
        `SADC_OFS_PF_MODE:
          if (w_strb_r[0])
          begin
            pf_nxt.pf_en = w_data_r[`SADC_BIT_PF_EN];
            pf_nxt.pf_ge = w_data_r[`SADC_BIT_PF_GE];
          end
        `SADC_OFS_PF_THRESH:
          if (w_strb_r[0])
            pf_nxt.thresh = w_data_r[7:0];
        `SADC_OFS_IRQ_MASK:
          if (w_strb_r[0])
            irq_mask_nxt = w_data_r[0];
        `SADC_OFS_PORT_EN:
          for (int b = 0; b < NUM_CH; b++)
            if (w_strb_r[b/8])
              port_en_nxt[b] = w_data_r[b];
        `SADC_OFS_IRQ_STAT:
          bresp_nxt = 2'b00;
        default:
          bresp_nxt = (is_res_word(aw_addr_r) || is_res_high(aw_addr_r)) ? 2'b00 : 2'b10;
      endcase
    end
    if (bvalid_r && s_axi_bready)
      bvalid_nxt = 1'b0;
  end

  // Read side: one-cycle latency, stat register cleared by its read
  always_comb
  begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && s_axi_rready)
      rvalid_nxt = 1'b0;
    if (s_axi_arvalid && !rvalid_r)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = 2'b00;
      rdata_nxt = 32'h0000_0000;
      unique case ({s_axi_araddr[7:2], 2'b00})
        `SADC_OFS_MODE_A:
          rdata_nxt[7:0] = {ctl_r.ce, 1'b0, ctl_r.mode, ctl_r.edge_sel, ctl_r.hw_trig, busy};
        `SADC_OFS_CONV_TIME: rdata_nxt[7:0] = conv_time_reg_r;
        `SADC_OFS_HW_TRIG: rdata_nxt[7:0] = hw_trigger_select_reg_r;
        `SADC_OFS_CHAN_SEL: rdata_nxt[3:0] = channel_select_reg_r;
        `SADC_OFS_PF_MODE: rdata_nxt[7:6] = {pf_r.pf_en, pf_r.pf_ge};
        `SADC_OFS_PF_THRESH: rdata_nxt[7:0] = pf_r.thresh;
        `SADC_OFS_IRQ_STAT: rdata_nxt[0] = irq_stat_r;
        `SADC_OFS_IRQ_MASK: rdata_nxt[0] = irq_mask_r;
        `SADC_OFS_PORT_EN: rdata_nxt[NUM_CH-1:0] = port_en_r;
        default:
          if (is_res_word(s_axi_araddr))
            rdata_nxt[15:0] = {result_mem_r[s_axi_araddr[5:2]], 6'b00_0000};
          else if (is_res_high(s_axi_araddr))
            rdata_nxt[7:0] = result_mem_r[s_axi_araddr[5:2]][RES_BITS-1 -: 8];
          else
            rresp_nxt = 2'b10;
      endcase
    end
  end

  // Conversion sequencing: triggers, scan stepping, abort on control writes
  always_comb
  begin
    armed_nxt = armed_r;
    cur_ch_nxt = cur_ch_r;
    start = 1'b0;
    abort = 1'b0;
    if (!ctl_r.ce)
    begin
      armed_nxt = 1'b0;
      abort = busy;
    end
    else if (ctl_write && busy)
    begin
      // Software mode restarts at once; hardware mode waits for the next trigger
      abort = 1'b1;
      armed_nxt = !ctl_r.hw_trig;
    end
    else if (ctl_r.hw_trig && !busy && (hw_trigger_select_reg_r[0] ? timer_trigger_i : trig_edge))
      armed_nxt = 1'b1;
    if (ctl_r.ce && !ctl_write && armed_r && !busy && !done)
    begin
      start = 1'b1;
      armed_nxt = 1'b0;
      if (ctl_r.mode == sadc_pkg::SADC_CONT_SCAN || ctl_r.mode == sadc_pkg::SADC_ONESHOT_SCAN)
        cur_ch_nxt = 4'h0;
      else
        cur_ch_nxt = channel_select_reg_r;
    end
    if (done)
    begin
      if ((ctl_r.mode == sadc_pkg::SADC_CONT_SCAN || ctl_r.mode == sadc_pkg::SADC_ONESHOT_SCAN)
          && cur_ch_r < channel_select_reg_r)
      begin
        cur_ch_nxt = cur_ch_r + 4'h1;
        start = 1'b1;
      end
      else if (ctl_r.mode == sadc_pkg::SADC_CONT_SELECT || ctl_r.mode == sadc_pkg::SADC_CONT_SCAN)
        armed_nxt = !ctl_r.hw_trig;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      ctl_r <= '0;
      pf_r <= '0;
      conv_time_reg_r <= `SADC_RESET_BYTE;
      hw_trigger_select_reg_r <= `SADC_RESET_BYTE;
      channel_select_reg_r <= 4'h0;
      port_en_r <= '0;
      irq_mask_r <= 1'b0;
      cur_ch_r <= 4'h0;
      armed_r <= 1'b0;
      aw_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_hold_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'b00;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'b00;
      div_cnt_r <= 4'h0;
    end
    else
    begin
      ctl_r <= ctl_nxt;
      pf_r <= pf_nxt;
      conv_time_reg_r <= conv_time_reg_nxt;
      hw_trigger_select_reg_r <= hw_trigger_select_reg_nxt;
      channel_select_reg_r <= channel_select_reg_nxt;
      port_en_r <= port_en_nxt;
      irq_mask_r <= irq_mask_nxt;
      cur_ch_r <= cur_ch_nxt;
      // Enabling in software mode arms the first conversion
      armed_r <= armed_nxt | (ctl_nxt.ce & ~ctl_r.ce & ~ctl_nxt.hw_trig);
      aw_hold_r <= aw_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_hold_r <= w_hold_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      div_cnt_r <= div_cnt_nxt;
    end
  end

  sadc_sar_core #(
    .RES_BITS(RES_BITS)
  ) u_core (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(start),
    .abort_i(abort),
    .step_en_i(step_en),
    .comp_i(comparator_i),
    .dac_code_o(dac_code_o),
    .busy_o(busy),
    .done_o(done),
    .result_o(result)
  );

  // Result memory written on the cycle the core reports done
  always_ff @(posedge core_clk_i)
  begin
    if (done)
      result_mem_r[cur_ch_r] <= result;
  end

  assign pf_hit = pf_r.pf_ge ? (result[RES_BITS-1 -: 8] >= pf_r.thresh)
                             : (result[RES_BITS-1 -: 8] < pf_r.thresh);
  assign end_event = done && (!pf_r.pf_en || pf_hit);

  // Sticky status: an event in the reading cycle wins over the clear
  assign irq_stat_nxt = end_event ? 1'b1 : (rd_stat ? 1'b0 : irq_stat_r);
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      irq_stat_r <= 1'b0;
    else
      irq_stat_r <= irq_stat_nxt;
  end

  assign conversion_end_irq_o = end_event;
  assign irq_o = irq_stat_r & irq_mask_r;
  assign analog_input_sel_o = cur_ch_r;
  assign sample_o = start;
  // Unselected pins are released to the general port function
  assign analog_pin_enable_o = port_en_r;
  assign s_axi_awready = !aw_hold_r;
  assign s_axi_wready = !w_hold_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  property p_irq_pulse;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      conversion_end_irq_o |=> !conversion_end_irq_o;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("end event longer than one cycle");

  property p_irq_needs_done;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      conversion_end_irq_o |-> (done && !busy && $past(busy));
  endproperty
  a_irq_needs_done: assert property (p_irq_needs_done) else $error("end event without done");

  property p_pf_gate;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (done && pf_r.pf_en && !pf_hit) |-> !conversion_end_irq_o;
  endproperty
  a_pf_gate: assert property (p_pf_gate) else $error("power-fail event without match");

  property p_result_store;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      done |=> result_mem_r[$past(cur_ch_r)] == $past(result);
  endproperty
  a_result_store: assert property (p_result_store) else $error("result not stored");

  sequence s_started;
    start && !abort;
  endsequence
  property p_busy_after_start;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      s_started |=> busy;
  endproperty
  a_busy_after_start: assert property (p_busy_after_start) else $error("busy not set");

  property p_done_bound;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (s_started ##1 (busy && !abort) [*8]) |-> ##[0:200] (done || !busy);
  endproperty
  a_done_bound: assert property (p_done_bound) else $error("conversion too long");

  property p_restart;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (ctl_write && busy && ctl_r.ce && ctl_nxt.ce && !ctl_r.hw_trig && !ctl_nxt.hw_trig)
        |-> ##[1:3] start;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart after control write");

  property p_edge_none;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (ctl_r.hw_trig && !hw_trigger_select_reg_r[0] && ctl_r.edge_sel == 2'b00 && !armed_r
       && !ctl_write) |=> !armed_r;
  endproperty
  a_edge_none: assert property (p_edge_none) else $error("edge seen while disabled");
endmodule : sadc_ctrl
`default_nettype wire

// *** hdl/sadc_sar_core.sv ***
// Successive approximation engine: one trial bit per step from MSB to LSB
`timescale 1ns/1ps
`default_nettype none
module sadc_sar_core #(
  parameter int RES_BITS = 10
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic step_en_i,
  input wire logic comp_i,
  output logic [RES_BITS-1:0] dac_code_o,
  output logic busy_o,
  output logic done_o,
  output logic [RES_BITS-1:0] result_o
);
  logic [RES_BITS-1:0] sar_r;
  logic [RES_BITS-1:0] sar_nxt;
  logic [RES_BITS-1:0] trial_r;
  logic [RES_BITS-1:0] trial_nxt;
  logic busy_r;
  logic busy_nxt;
  logic done_r;
  logic done_nxt;
  logic [RES_BITS-1:0] res_r;
  logic [RES_BITS-1:0] res_nxt;

  always_comb
  begin
    sar_nxt = sar_r;
    trial_nxt = trial_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    res_nxt = res_r;
    if (abort_i)
    begin
      busy_nxt = 1'b0;
      trial_nxt = '0;
    end
    else if (start_i)
    begin
      // Trial starts at the MSB with all lower bits clear
      busy_nxt = 1'b1;
      sar_nxt = '0;
      trial_nxt = {1'b1, {(RES_BITS-1){1'b0}}};
    end
    else if (busy_r && step_en_i)
    begin
      if (comp_i)
        sar_nxt = sar_r | trial_r;
      trial_nxt = trial_r >> 1;
      if (trial_r[0])
      begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        res_nxt = comp_i ? (sar_r | trial_r) : sar_r;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      sar_r <= '0;
      trial_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      res_r <= '0;
    end
    else
    begin
      sar_r <= sar_nxt;
      trial_r <= trial_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      res_r <= res_nxt;
    end
  end

  assign dac_code_o = sar_r | trial_r;
  assign busy_o = busy_r;
  assign done_o = done_r;
  assign result_o = res_r;
endmodule : sadc_sar_core
`default_nettype wire

// *** tb/sadc_comp_model.sv ***
// Stand-in for the comparator and compare DAC on the analog side
`timescale 1ns/1ps
`default_nettype none
module sadc_comp_model (
  input wire logic [9:0] level_i,
  input wire logic [9:0] dac_code_i,
  output logic comp_o
);
  // Ideal comparator with no offset, so every code is reachable exactly
  assign comp_o = (level_i >= dac_code_i);
endmodule : sadc_comp_model
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, bresp_seen;
  logic [3:0] sel;
  logic [31:0] s_axi_rdata;
  logic pin = 1'b1, tmr = 1'b0, comp, evt, irq, smp;
  logic [9:0] lvl = 10'h000, dac, pen;
  int failures = 0, total_checks = 0, evts = 0, smps = 0;
  always #12.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (evt === 1'b1) evts <= evts + 1;
  always @(posedge core_clk_i) if (smp === 1'b1) smps <= smps + 1;
  sadc_ctrl #(.NUM_CH(10), .RES_BITS(10)) dut (.core_clk_i, .sys_rst_i, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .external_trigger_pin_i(pin), .timer_trigger_i(tmr), .comparator_i(comp),
    .dac_code_o(dac), .analog_input_sel_o(sel), .sample_o(smp), .analog_pin_enable_o(pen),
    .conversion_end_irq_o(evt), .irq_o(irq));
  sadc_comp_model model (.level_i(lvl), .dac_code_i(dac), .comp_o(comp));
  task automatic give_verdict();
    if (failures == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  // Ready levels are sampled at the falling edge, where they equal the next rising edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t;
    @(posedge core_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b_t = 1'b0;
    while (!b_t)
    begin
      @(negedge core_clk_i);
      aw_t = s_axi_awvalid & s_axi_awready;
      w_t = s_axi_wvalid & s_axi_wready;
      b_t = s_axi_bvalid;
      bresp_seen = s_axi_bresp;
      @(posedge core_clk_i);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (b_t) s_axi_bready <= 1'b0;
    end
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, got;
    @(posedge core_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    got = 1'b0;
    while (!got)
    begin
      @(negedge core_clk_i);
      ar_t = s_axi_arvalid & s_axi_arready;
      got = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge core_clk_i);
      if (ar_t) s_axi_arvalid <= 1'b0;
      if (got) s_axi_rready <= 1'b0;
    end
  endtask : axr
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk("read data", exp, d);
  endtask : rchk
  // One conversion or scan; a differing ch2 rewrites the channel while busy
  task automatic conv(input logic [7:0] mode, input logic [3:0] ch, input logic [3:0] ch2,
      input logic [9:0] level, input logic use_tmr, input int n);
    int e0;
    int s0;
    logic [31:0] d;
    logic [1:0] r;
    axw(8'h00, 32'h0000_0000);
    axw(8'h0C, {28'h000_0000, ch});
    axw(8'h08, {31'h0000_0000, use_tmr});
    lvl <= level;
    e0 = evts;
    s0 = smps;
    axw(8'h00, {24'h00_0000, mode});
    if (!mode[1])
    begin
      axr(8'h00, d, r);
      chk("busy flag", 32'h0000_0001, {31'h0000_0000, d[0]});
    end
    if (ch2 != ch)
      axw(8'h0C, {28'h000_0000, ch2});
    @(posedge core_clk_i);
    if (use_tmr) tmr <= 1'b1;
    else pin <= 1'b0;
    @(posedge core_clk_i);
    tmr <= 1'b0;
    repeat (7) @(posedge core_clk_i);
    pin <= 1'b1;
    // Longest conversion at step divider 7 is well under this span
    repeat (400) @(posedge core_clk_i);
    chk("end events", n, 32'(evts - e0));
    chk("starts", 32'((mode[1] && n == 0) ? 0 : (mode[4] ? ch + 1 : 1) + (ch2 != ch)),
        32'(smps - s0));
    if (n != 0)
    begin
      chk("channel", {28'h000_0000, ch2}, {28'h000_0000, sel});
      rchk(8'h40 + {2'b00, ch2, 2'b00}, {16'h0000, level, 6'h00});
      rchk(8'h80 + {2'b00, ch2, 2'b00}, {24'h00_0000, level[9:2]});
    end
    chk("irq level", 32'(n != 0), {31'h0000_0000, irq});
    rchk(8'h18, 32'(n != 0));
    rchk(8'h18, 32'h0000_0000);
  endtask : conv
  task automatic sc_regs();
    logic [31:0] d;
    logic [1:0] r;
    rchk(8'h00, 32'h0000_0000);
    axw(8'h00, 32'h0000_0001);
    rchk(8'h00, 32'h0000_0000);
    axr(8'h3C, d, r);
    chk("unmapped resp", 32'h0000_0002, {30'h0000_0000, r});
    axw(8'h04, 32'h0000_0007);
    rchk(8'h04, 32'h0000_0007);
    axw(8'h3C, 32'h0000_0000);
    chk("write resp", 32'h0000_0002, {30'h0000_0000, bresp_seen});
    axw(8'h20, 32'h0000_02A5);
    chk("pin enable", 32'h0000_02A5, {22'h00_0000, pen});
    rchk(8'h20, 32'h0000_02A5);
    axw(8'h1C, 32'h0000_0001);
  endtask : sc_regs
  task automatic sc_modes();
    conv(8'hA0, 4'd3, 4'd3, 10'h2A5, 1'b0, 1);
    conv(8'hA0, 4'd1, 4'd2, 10'h155, 1'b0, 1);
    conv(8'hB0, 4'd2, 4'd2, 10'h0F3, 1'b0, 3);
    axw(8'h14, 32'h0000_0080);
    axw(8'h10, 32'h0000_00C0);
    conv(8'hA0, 4'd4, 4'd4, 10'h100, 1'b0, 0);
    conv(8'hA0, 4'd4, 4'd4, 10'h3F0, 1'b0, 1);
    axw(8'h10, 32'h0000_0080);
    conv(8'hA0, 4'd9, 4'd9, 10'h100, 1'b0, 1);
    axw(8'h10, 32'h0000_0000);
  endtask : sc_modes
  task automatic sc_hw_trig();
    conv(8'hA2, 4'd0, 4'd0, 10'h3FF, 1'b1, 1);
    conv(8'hA6, 4'd6, 4'd6, 10'h001, 1'b0, 1);
    conv(8'hAA, 4'd7, 4'd7, 10'h200, 1'b0, 1);
    conv(8'hA2, 4'd5, 4'd5, 10'h111, 1'b0, 0);
  endtask : sc_hw_trig
  task automatic sc_cont(input logic [7:0] mode);
    int e0;
    logic [31:0] d;
    logic [1:0] r;
    axw(8'h00, 32'h0000_0000);
    axw(8'h0C, 32'h0000_0001);
    e0 = evts;
    axw(8'h00, {24'h00_0000, mode});
    repeat (400) @(posedge core_clk_i);
    axw(8'h00, 32'h0000_0000);
    chk("repeats", 32'h0000_0001, 32'(evts - e0 >= 3));
    axr(8'h18, d, r);
  endtask : sc_cont
  initial
  begin
    repeat (12) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    sc_regs();
    sc_modes();
    sc_hw_trig();
    sc_cont(8'h80);
    sc_cont(8'h90);
    give_verdict();
  end
  initial
  begin
    repeat (40000) @(posedge core_clk_i);
    failures++;
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
